// ===== src/rsi_top.sv
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module rsi_top #(
  parameter int              INIT_CYCLES = rsi_pkg::INIT_CYCLES_DEFAULT,
  parameter int              SP_W        = 4,
  parameter logic [SP_W-1:0] STACK_TOP   = '1
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  // Reset sources and core state
  input  wire logic              low_voltage_reset_n,
  input  wire logic              watchdog_timeout,
  input  wire logic [1:0]        cpu_mode,
  // Reset state outputs
  output logic                   core_reset_n,
  output logic                   pc_clear,
  output logic                   sp_load,
  output logic      [SP_W-1:0]   stack_ptr,
  output logic                   int_disable_all,
  output logic                   timer_off,
  output logic                   port_dir_input,
  output logic                   watchdog_clear,
  output logic                   timeout_flag,
  output logic                   powerdown_flag,
  output logic      [7:0]        watchdog_control_reg,
  output logic      [7:0]        low_voltage_select_reg
);

  localparam int CNT_W = $clog2(INIT_CYCLES + 1);

  // ----------------------------------------------------------------
  // Source capture
  // ----------------------------------------------------------------
  logic                 lowv_sync;
  logic                 lowv_prev;
  rsi_pkg::rsi_state_t  state;
  rsi_pkg::rsi_state_t  next_state;
  rsi_pkg::rsi_kind_t   kind;
  rsi_pkg::rsi_kind_t   next_kind;
  logic [CNT_W-1:0]     cnt;
  logic [3:0]           irq_status;
  logic [3:0]           irq_mask;
  logic                 ack;
  logic [7:0]           hold_len;

  rsi_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_lowv_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (low_voltage_reset_n),
    .q       (lowv_sync)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lowv_prev <= 1'b1;
    end else begin
      lowv_prev <= lowv_sync;
    end
  end

  // Low-voltage detection is off while powered down, so halted modes ignore it
  wire halted      = (cpu_mode == rsi_pkg::RSI_MODE_IDLE) ||
                     (cpu_mode == rsi_pkg::RSI_MODE_SLEEP);
  wire lowv_event  = lowv_prev & ~lowv_sync & ~halted;
  wire in_run      = (state == rsi_pkg::RSI_ST_RUN);
  // Sources arriving while a reset is being applied are absorbed by it
  wire capture     = in_run & (lowv_event | watchdog_timeout);
  wire cap_lowv    = capture & lowv_event;
  wire cap_dog_run = capture & ~lowv_event & ~halted;
  wire cap_halt    = capture & ~lowv_event & halted;
  wire cap_full    = cap_lowv | cap_dog_run;

  // Running watchdog reset follows the low-voltage path
  assign next_kind = cap_lowv    ? rsi_pkg::RSI_KIND_LOWV :
                     cap_dog_run ? rsi_pkg::RSI_KIND_DOG_RUN :
                                   rsi_pkg::RSI_KIND_DOG_HALT;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      rsi_pkg::RSI_ST_RUN: begin
        next_state = capture ? rsi_pkg::RSI_ST_APPLY : rsi_pkg::RSI_ST_RUN;
      end
      rsi_pkg::RSI_ST_APPLY: begin
        next_state = (cnt == '0) ? rsi_pkg::RSI_ST_RUN : rsi_pkg::RSI_ST_APPLY;
      end
      default: begin
        next_state = rsi_pkg::RSI_ST_APPLY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= rsi_pkg::RSI_ST_APPLY;
      kind  <= rsi_pkg::RSI_KIND_POR;
      cnt   <= CNT_W'(INIT_CYCLES - 1);
    end else begin
      state <= next_state;
      if (capture) begin
        kind <= next_kind;
        cnt  <= CNT_W'(INIT_CYCLES - 1);
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset state outputs
  // ----------------------------------------------------------------
  wire applying  = (state == rsi_pkg::RSI_ST_APPLY);
  wire full_kind = (kind != rsi_pkg::RSI_KIND_DOG_HALT);

  assign core_reset_n    = ~applying;
  assign pc_clear        = applying;
  assign sp_load         = applying;
  assign int_disable_all = applying & full_kind;
  assign timer_off       = applying & full_kind;
  assign port_dir_input  = applying & full_kind;
  // Counter is held clear while applying a full reset and counts from the first run cycle
  assign watchdog_clear  = applying & full_kind;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stack_ptr <= STACK_TOP;
    end else if (cap_full) begin
      stack_ptr <= STACK_TOP;
    end else if (cap_halt) begin
      stack_ptr <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       wr_fire   = avs_write & ack & avs_byteenable[0];
  wire       sel_ctrl  = (avs_address == rsi_pkg::REG_CTRL);
  wire       sel_wd    = (avs_address == rsi_pkg::REG_WD_CTRL);
  wire       sel_lv    = (avs_address == rsi_pkg::REG_LV_SEL);
  wire       sel_ists  = (avs_address == rsi_pkg::REG_IRQ_STATUS);
  wire       sel_imsk  = (avs_address == rsi_pkg::REG_IRQ_MASK);
  wire       flag_clr  = wr_fire & sel_ctrl & avs_writedata[rsi_pkg::CTRL_CLR_BIT];
  wire       halt_wr   = wr_fire & sel_ctrl & avs_writedata[rsi_pkg::CTRL_HALT_BIT];
  wire [7:0] wdata     = avs_writedata[7:0];

  wire [7:0] status_word = {3'h0, applying, kind, powerdown_flag, timeout_flag};
  wire [7:0] rd_byte =
    (avs_address == rsi_pkg::REG_STATUS) ? status_word :
    sel_wd   ? watchdog_control_reg :
    sel_lv   ? low_voltage_select_reg :
    sel_ists ? {4'h0, irq_status} :
    sel_imsk ? {4'h0, irq_mask} :
               8'h00;

  // One wait cycle: data is captured on the first edge, taken on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset flags
  // ----------------------------------------------------------------
  // A reset source wins over any software write to the flags in the same cycle
  wire sw_flags    = ~capture;
  wire set_timeout = cap_dog_run | cap_halt;
  wire set_pwrdn   = cap_halt | (halt_wr & sw_flags);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= 1'b0;
    end else begin
      if (set_timeout) begin
        timeout_flag <= 1'b1;
      end else if ((flag_clr | halt_wr) & sw_flags) begin
        timeout_flag <= 1'b0;
      end
      if (set_pwrdn) begin
        powerdown_flag <= 1'b1;
      end else if (flag_clr & sw_flags) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register images
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      watchdog_control_reg   <= rsi_pkg::WATCHDOG_CTRL_RESET;
      low_voltage_select_reg <= rsi_pkg::LOW_VOLT_SEL_RESET;
    end else if (cap_full) begin
      watchdog_control_reg   <= rsi_pkg::WATCHDOG_CTRL_RESET;
      low_voltage_select_reg <= rsi_pkg::LOW_VOLT_SEL_RESET;
    end else if (!cap_halt) begin
      if (wr_fire & sel_wd) begin
        watchdog_control_reg <= wdata;
      end
      if (wr_fire & sel_lv) begin
        low_voltage_select_reg <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire [3:0] irq_set = {cap_halt, cap_dog_run, cap_lowv, 1'b0};
  wire [3:0] irq_clr = (wr_fire & sel_ists) ? avs_writedata[3:0] : 4'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status <= rsi_pkg::IRQ_STATUS_RESET;
      irq_mask   <= rsi_pkg::IRQ_MASK_RESET;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
      if (wr_fire & sel_imsk) begin
        irq_mask <= avs_writedata[3:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_len <= 8'h00;
    end else if (core_reset_n) begin
      hold_len <= 8'h00;
    end else begin
      hold_len <= hold_len + 8'h01;
    end
  end

  AST_HALT_PC_SP: assert property (@(posedge clk) disable iff (!reset_n)
    cap_halt |=> pc_clear && !core_reset_n && stack_ptr == '0 && timeout_flag)
    else $error("halted watchdog reset did not clear pc and sp");

  AST_HALT_KEEPS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_halt |=> $stable(watchdog_control_reg) && $stable(low_voltage_select_reg)
                 && !int_disable_all && !timer_off && !port_dir_input)
    else $error("halted watchdog reset changed other state");

  AST_POR_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> !timeout_flag && !powerdown_flag)
    else $error("power-on did not clear flags");

  AST_LOWV_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_lowv |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("low-voltage reset changed flags");

  AST_DOG_RUN_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_dog_run |=> timeout_flag && $stable(powerdown_flag))
    else $error("running watchdog reset flags wrong");

  AST_DOG_HALT_FLAGS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_halt |=> timeout_flag && powerdown_flag)
    else $error("halted watchdog reset flags wrong");

  AST_FULL_OUTS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_full |=> (int_disable_all && timer_off && port_dir_input && watchdog_clear)
                 throughout (!core_reset_n [*1]) ##1 1'b1)
    else $error("full reset outputs missing");

  AST_SP_TOP: assert property (@(posedge clk) disable iff (!reset_n)
    cap_full |=> stack_ptr == STACK_TOP && pc_clear)
    else $error("stack pointer not at top after full reset");

  AST_FULL_LOADS: assert property (@(posedge clk) disable iff (!reset_n)
    cap_full |=> watchdog_control_reg == rsi_pkg::WATCHDOG_CTRL_RESET
                 && low_voltage_select_reg == rsi_pkg::LOW_VOLT_SEL_RESET)
    else $error("control register images not loaded");

  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(core_reset_n) |-> hold_len == INIT_CYCLES && pc_clear == 1'b0)
    else $error("core hold length wrong");

endmodule

// ===== shared/rsi_pkg.sv
// ----------------------------------------------------------------
// Reset state initialiser constants
// ----------------------------------------------------------------
package rsi_pkg;

  // ----------------------------------------------------------------
  // Core operating modes, as reported by the core
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSI_MODE_NORMAL = 2'b00,
    RSI_MODE_SLOW   = 2'b01,
    RSI_MODE_IDLE   = 2'b10,
    RSI_MODE_SLEEP  = 2'b11
  } rsi_mode_t;

  // ----------------------------------------------------------------
  // Reset kinds, also the irq status bit positions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSI_KIND_POR      = 2'b00,
    RSI_KIND_LOWV     = 2'b01,
    RSI_KIND_DOG_RUN  = 2'b10,
    RSI_KIND_DOG_HALT = 2'b11
  } rsi_kind_t;

  typedef enum logic [0:0] {
    RSI_ST_RUN   = 1'b0,
    RSI_ST_APPLY = 1'b1
  } rsi_state_t;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  REG_STATUS     = 6'h00;
  localparam logic [5:0]  REG_CTRL       = 6'h04;
  localparam logic [5:0]  REG_WD_CTRL    = 6'h08;
  localparam logic [5:0]  REG_LV_SEL     = 6'h0c;
  localparam logic [5:0]  REG_IRQ_STATUS = 6'h10;
  localparam logic [5:0]  REG_IRQ_MASK   = 6'h14;

  // Status fields
  localparam int          ST_TIMEOUT_BIT = 0;
  localparam int          ST_PWRDN_BIT   = 1;
  localparam int          ST_KIND_LSB    = 2;
  localparam int          ST_HOLD_BIT    = 4;
  // Control fields, write-one pulses
  localparam int          CTRL_CLR_BIT   = 0;
  localparam int          CTRL_HALT_BIT  = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WATCHDOG_CTRL_RESET = 8'h53;
  localparam logic [7:0]  LOW_VOLT_SEL_RESET  = 8'h55;
  localparam logic [3:0]  IRQ_STATUS_RESET    = 4'h1;
  localparam logic [3:0]  IRQ_MASK_RESET      = 4'h0;
  localparam int          INIT_CYCLES_DEFAULT = 4;

endpackage

// ===== src/rsi_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------
module rsi_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta[i] <= RESET_VAL;
          q[i]    <= RESET_VAL;
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ===== testbench/reset_state_initialiser_tb.sv
`timescale 1ns/1ps
module reset_state_initialiser_tb;
  localparam int INIT = 3;

  logic        clk;
  logic        reset_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        low_voltage_reset_n;
  logic        watchdog_timeout;
  logic [1:0]  cpu_mode;
  logic        core_reset_n;
  logic        pc_clear;
  logic        sp_load;
  logic [3:0]  stack_ptr;
  logic        int_disable_all;
  logic        timer_off;
  logic        port_dir_input;
  logic        watchdog_clear;
  logic        timeout_flag;
  logic        powerdown_flag;
  logic [7:0]  watchdog_control_reg;
  logic [7:0]  low_voltage_select_reg;
  int          n_errors;
  int          checks_done;
  logic [31:0] d;

  rsi_top #(.INIT_CYCLES(INIT)) rsi_top_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .low_voltage_reset_n(low_voltage_reset_n), .watchdog_timeout(watchdog_timeout),
    .cpu_mode(cpu_mode), .core_reset_n(core_reset_n), .pc_clear(pc_clear),
    .sp_load(sp_load), .stack_ptr(stack_ptr), .int_disable_all(int_disable_all),
    .timer_off(timer_off), .port_dir_input(port_dir_input), .watchdog_clear(watchdog_clear),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .watchdog_control_reg(watchdog_control_reg),
    .low_voltage_select_reg(low_voltage_select_reg)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task summarize;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Starts one edge later so a release and a new request never share a time step
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk(1'b1, 1'b0, "bus timeout");
      summarize;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [31:0] v);
    bus(1'b1, a, v, d);
  endtask

  // Waits for the apply phase, checks its outputs, length and the reported kind
  task apply_chk(input logic full, input logic to_e, input logic pd_e,
                 input logic [7:0] wd_e, input logic [7:0] lv_e, input logic [1:0] kd);
    int n;
    n = 0;
    while (core_reset_n !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(core_reset_n), 32'h0, "core held");
    chk(32'({pc_clear, sp_load, int_disable_all, timer_off, port_dir_input, watchdog_clear}),
        full ? 32'h3f : 32'h30, "apply outputs");
    chk(32'(stack_ptr), full ? 32'hf : 32'h0, "stack pointer");
    chk(32'({timeout_flag, powerdown_flag}), 32'({to_e, pd_e}), "flags");
    chk(32'({watchdog_control_reg, low_voltage_select_reg}), 32'({wd_e, lv_e}), "images");
    n = 0;
    while (core_reset_n === 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n), 32'(INIT), "apply length");
    chk(32'({core_reset_n, pc_clear}), 32'h2, "released");
    bus(1'b0, rsi_pkg::REG_STATUS, 32'h0, d);
    chk(d, 32'({1'b0, kd, pd_e, to_e}), "status");
    bus(1'b0, rsi_pkg::REG_IRQ_STATUS, 32'h0, d);
    chk(d & (32'h1 << kd), 32'h1 << kd, "event bit");
    wr(rsi_pkg::REG_IRQ_STATUS, 32'hf);
  endtask

  // Gives both control images values unlike their reset values, then writes ctl to the control register
  task prime(input logic [31:0] ctl);
    wr(rsi_pkg::REG_WD_CTRL, 32'ha5);
    wr(rsi_pkg::REG_LV_SEL, 32'h3c);
    wr(rsi_pkg::REG_CTRL, ctl);
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    reset_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    low_voltage_reset_n = 1'b1;
    watchdog_timeout = 1'b0;
    cpu_mode = 2'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    apply_chk(1'b1, 1'b0, 1'b0, 8'h53, 8'h55, 2'h0);
    bus(1'b0, 6'h20, 32'h0, d);
    chk(d, 32'h0, "unmapped read");
    wr(rsi_pkg::REG_IRQ_MASK, 32'h1);
    bus(1'b0, rsi_pkg::REG_IRQ_STATUS, 32'h0, d);
    chk(d, 32'h0, "event cleared");
    wr(rsi_pkg::REG_IRQ_MASK, 32'h2);
    prime(32'h2);
    avs_byteenable <= 4'h0;
    wr(rsi_pkg::REG_WD_CTRL, 32'h00);
    avs_byteenable <= 4'h1;
    bus(1'b0, rsi_pkg::REG_WD_CTRL, 32'h0, d);
    chk(d, 32'ha5, "byte enable off");
    @(posedge clk);
    low_voltage_reset_n <= 1'b0;
    #1;
    apply_chk(1'b1, 1'b0, 1'b1, 8'h53, 8'h55, 2'h1);
    #1;
    chk(32'(irq), 32'h0, "irq after clear");
    @(posedge clk);
    low_voltage_reset_n <= 1'b1;
    // Unmasked event raises the line until its bit is cleared
    wr(rsi_pkg::REG_IRQ_MASK, 32'hf);
    @(posedge clk);
    low_voltage_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(irq), 32'h1, "irq raised");
    wr(rsi_pkg::REG_IRQ_MASK, 32'h0);
    #1;
    chk(32'(irq), 32'h0, "irq masked");
    wr(rsi_pkg::REG_IRQ_MASK, 32'hf);
    wr(rsi_pkg::REG_IRQ_STATUS, 32'hf);
    #1;
    chk(32'(irq), 32'h0, "irq cleared");
    @(posedge clk);
    low_voltage_reset_n <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      prime(m == 1 ? 32'h2 : 32'h1);
      @(posedge clk);
      cpu_mode <= 2'(m);
      watchdog_timeout <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b0;
      #1;
      if (m < 2) begin
        apply_chk(1'b1, 1'b1, m == 1, 8'h53, 8'h55, 2'h2);
      end else begin
        apply_chk(1'b0, 1'b1, 1'b1, 8'ha5, 8'h3c, 2'h3);
      end
    end
    // A supply dip while halted is not taken as a reset
    @(posedge clk);
    cpu_mode <= 2'h2;
    low_voltage_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(core_reset_n), 32'h1, "low voltage while halted");
    summarize;
  end

  initial begin
    #1000000;
    chk(1'b1, 1'b0, "run timeout");
    summarize;
  end
endmodule
